// >>> design/rsc_cfg.svh
// Constants of the reset source controller: offsets, bit positions, times.
// Assumes a 250 MHz CPU clock and a byte-addressed AXI4-Lite register bus.
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
`define RSC_CLK_MHZ         250
`define RSC_ADDR_W          8
`define RSC_SYNC_W          6
// Register byte offsets
`define RSC_OFF_VDET_STATUS 8'h00
`define RSC_OFF_VDET_CTRL   8'h04
`define RSC_OFF_LVI_CTRL    8'h08
`define RSC_OFF_PROTECT     8'h0C
`define RSC_OFF_PROC_MODE   8'h10
`define RSC_OFF_CLK_CTRL    8'h14
`define RSC_OFF_RST_CAUSE   8'h18
`define RSC_LAST_WORD       6'h06
// Field positions
`define RSC_BIT_ABOVE_FLAG  3
`define RSC_BIT_RLD_EN      6
`define RSC_BIT_LVD_EN      7
`define RSC_BIT_LVI_EN      0
`define RSC_BIT_STOP_EXIT   1
`define RSC_BIT_LV_DET      2
`define RSC_BIT_VWR_EN      3
`define RSC_BIT_SW_RST      3
`define RSC_BIT_WDT_SEL     0
`define RSC_BIT_OSC_ACT     1
// Reset values
`define RSC_RST_CAUSE_INIT  5'h01
`define RSC_RST_STRETCH     4'h8
// Times in ns
`define RSC_SETTLE_WAIT_NS  100000
`define RSC_RELEASE_WAIT_NS 200000
// Bus answers
`define RSC_RESP_OKAY       2'h0
`define RSC_RESP_SLVERR     2'h2
`endif

// >>> design/rsc_pkg.sv
// Types of the reset source controller.
// Assumes nothing beyond a SystemVerilog compiler.
package rsc_pkg;
  // Brown-out sequencer states, one-hot
  typedef enum logic [2:0] {
    BOR_IDLE = 3'h1,
    BOR_HOLD = 3'h2,
    BOR_WAIT = 3'h4
  } rsc_bor_state_t;
endpackage

// >>> design/rsc_sync.sv
// Two-flop synchroniser bank for pins and comparator outputs.
// Assumes each bit is a slow level; multi-bit coherence is not kept.
`timescale 1ns/1ps
module rsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      // First stage feeds only the second stage
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta_reg[g] <= 1'h0;
          o_sync[g]   <= 1'h0;
        end else begin
          meta_reg[g] <= i_async[g];
          o_sync[g]   <= meta_reg[g];
        end
      end
    end
  endgenerate
endmodule

// >>> design/rsc_top.sv
// Reset source controller: merges pin, brown-out, software, watchdog and
// oscillator-stop resets, and holds the voltage detector control bits.
// Assumes analog comparators outside; their outputs arrive asynchronously.
`timescale 1ns/1ps
`include "rsc_cfg.svh"
// Overview of operation
// - Reset level detect enabled: supply at reset threshold resets at once
// - Stay in reset while low; after release threshold wait, then run
// - Brown-out reset inactive in stop mode; no reset, no stop exit
// - Brown-out reset resets same pins and registers as pin reset; bus pin enable follows the reset pin only
// - Writing 1 to software reset request resets all but preserved set
// - Software, watchdog, oscillator resets keep processor mode bits
// - Watchdog reset select 1 plus underflow resets all but preserved set
// - Action select 0 plus oscillator stop resets and halts the device
// - Above threshold flag follows supply; reads 1 while detector disabled
// - Voltage detect registers survive software, watchdog, oscillator resets
// - Voltage register writes need the protect write enable bit at 1
// - Detector works only after settle wait following its enable
// - Low voltage detected flag forced 0 while detector disabled
// - Writing 0 clears low voltage detected flag; writing 1 does nothing
// - During pin reset bus pins follow boot mode pin
// - Pin rising edge resets CPU and registers, then runs
// - Detected flag sets when supply crosses low voltage threshold
module rsc_top #(
  parameter int CNT_W           = 24,
  parameter int SETTLE_WAIT_NS  = `RSC_SETTLE_WAIT_NS,
  parameter int RELEASE_WAIT_NS = `RSC_RELEASE_WAIT_NS
) (
  input  wire logic                   I_CLK,
  input  wire logic                   I_RST_N,
  input  wire logic                   I_RESET_PIN_N,
  input  wire logic                   I_BOOT_MODE,
  input  wire logic                   I_BELOW_RESET_THR,
  input  wire logic                   I_ABOVE_RELEASE_THR,
  input  wire logic                   I_ABOVE_LV_THR,
  input  wire logic                   I_OSC_STOPPED,
  input  wire logic                   I_WDT_UNDERFLOW,
  input  wire logic                   I_STOP_MODE,
  input  wire logic                   I_AWVALID,
  output logic                        O_AWREADY,
  input  wire logic [`RSC_ADDR_W-1:0] I_AWADDR,
  input  wire logic                   I_WVALID,
  output logic                        O_WREADY,
  input  wire logic [31:0]            I_WDATA,
  input  wire logic [3:0]             I_WSTRB,
  output logic                        O_BVALID,
  input  wire logic                   I_BREADY,
  output logic      [1:0]             O_BRESP,
  input  wire logic                   I_ARVALID,
  output logic                        O_ARREADY,
  input  wire logic [`RSC_ADDR_W-1:0] I_ARADDR,
  output logic                        O_RVALID,
  input  wire logic                   I_RREADY,
  output logic      [31:0]            O_RDATA,
  output logic      [1:0]             O_RRESP,
  output logic                        O_SYS_RST_N,
  output logic                        O_HW_RST_N,
  output logic                        O_CPU_HALT,
  output logic      [1:0]             O_PROC_MODE,
  output logic                        O_BUS_PIN_OE,
  output logic                        O_CHIP_SELECT_ZERO,
  output logic                        O_WRITE_STROBE,
  output logic                        O_READ_STROBE,
  output logic                        O_ADDR_LATCH_STROBE
);
  // Least times round up to whole cycles, never below one
  localparam int SETTLE_RAW  = (SETTLE_WAIT_NS * `RSC_CLK_MHZ + 999) / 1000;
  localparam int SETTLE_CYC  = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
  localparam int RELEASE_RAW = (RELEASE_WAIT_NS * `RSC_CLK_MHZ + 999) / 1000;
  localparam int RELEASE_CYC = (RELEASE_RAW < 1) ? 1 : RELEASE_RAW;

  // Word decode, shared by the read and write paths
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a[7:2] == off[7:2]);
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[7:2] <= `RSC_LAST_WORD);
  endfunction

  logic [`RSC_SYNC_W-1:0] sync_in;
  logic [`RSC_SYNC_W-1:0] sync_out;
  logic                   pin_n_s;
  logic                   boot_s;
  logic                   below_s;
  logic                   above_rel_s;
  logic                   above_lv_s;
  logic                   osc_s;

  // Pins and comparators cross into the CPU clock before any use
  assign sync_in = {I_OSC_STOPPED, I_ABOVE_LV_THR, I_ABOVE_RELEASE_THR,
                    I_BELOW_RESET_THR, I_BOOT_MODE, I_RESET_PIN_N};

  rsc_sync #(
    .WIDTH (`RSC_SYNC_W)
  ) u_sync (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_async (sync_in),
    .o_sync  (sync_out)
  );

  assign pin_n_s     = sync_out[0];
  assign boot_s      = sync_out[1];
  assign below_s     = sync_out[2];
  assign above_rel_s = sync_out[3];
  assign above_lv_s  = sync_out[4];
  assign osc_s       = sync_out[5];

  // Register state
  logic [1:0]             det_en_reg;
  logic                   lvi_en_reg;
  logic                   stop_exit_reg;
  logic                   lv_det_reg;
  logic                   vwr_en_reg;
  logic [1:0]             pm_reg;
  logic                   sw_req_reg;
  logic                   wdt_sel_reg;
  logic                   osc_act_reg;
  logic [4:0]             cause_reg;
  logic                   lv_prev_reg;
  logic                   osc_halt_reg;
  logic [CNT_W-1:0]       settle_cnt_reg [2];
  logic [1:0]             settled_reg;
  logic [CNT_W-1:0]       rel_cnt_reg;
  rsc_pkg::rsc_bor_state_t bor_reg;
  rsc_pkg::rsc_bor_state_t bor_next;
  logic [3:0]             sys_cnt_reg;
  logic [3:0]             hw_cnt_reg;

  // Bus slave state
  logic                   aw_full_reg;
  logic                   w_full_reg;
  logic [`RSC_ADDR_W-1:0] aw_addr_reg;
  logic [31:0]            w_data_reg;
  logic                   w_lane0_reg;
  logic                   aw_full_next;
  logic                   w_full_next;
  logic                   bvalid_next;
  logic                   wr_fire;
  logic [31:0]            rd_mux;

  // Decoded writes
  logic wr_ok;
  logic wr_vdet;
  logic wr_lvi;
  logic wr_prot;
  logic wr_pm;
  logic wr_clk;

  assign wr_fire = aw_full_reg & w_full_reg & ~O_BVALID;
  assign wr_ok   = wr_fire & w_lane0_reg;
  assign wr_vdet = wr_ok & vwr_en_reg & addr_hit(aw_addr_reg, `RSC_OFF_VDET_CTRL);
  assign wr_lvi  = wr_ok & vwr_en_reg & addr_hit(aw_addr_reg, `RSC_OFF_LVI_CTRL);
  assign wr_prot = wr_ok & addr_hit(aw_addr_reg, `RSC_OFF_PROTECT);
  assign wr_pm   = wr_ok & addr_hit(aw_addr_reg, `RSC_OFF_PROC_MODE);
  assign wr_clk  = wr_ok & addr_hit(aw_addr_reg, `RSC_OFF_CLK_CTRL);

  // Reset sources
  logic lv_ok;
  logic lv_cross;
  logic bor_trip;
  logic wdt_hit;
  logic hw_src;
  logic [4:0] src;

  assign lv_ok    = det_en_reg[1] & settled_reg[1];
  assign lv_cross = lv_ok & (above_lv_s ^ lv_prev_reg);
  assign bor_trip = det_en_reg[0] & settled_reg[0] & below_s & ~I_STOP_MODE;
  assign wdt_hit  = I_WDT_UNDERFLOW & wdt_sel_reg;
  assign hw_src   = ~pin_n_s | (bor_reg != rsc_pkg::BOR_IDLE);
  assign src      = {osc_halt_reg, wdt_hit, sw_req_reg,
                     bor_reg != rsc_pkg::BOR_IDLE, ~pin_n_s};

  // Detector settle timers, one per enable bit
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_settle
      always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          settle_cnt_reg[g] <= CNT_W'(SETTLE_CYC);
          settled_reg[g]    <= 1'h0;
        end else if (!det_en_reg[g]) begin
          settle_cnt_reg[g] <= CNT_W'(SETTLE_CYC);
          settled_reg[g]    <= 1'h0;
        end else if (settle_cnt_reg[g] != '0) begin
          settle_cnt_reg[g] <= settle_cnt_reg[g] - CNT_W'(1);
        end else begin
          settled_reg[g]    <= 1'h1;
        end
      end
    end
  endgenerate

  // Brown-out sequencer: trip, hold while low, timed release
  always_comb begin
    bor_next = bor_reg;
    case (bor_reg)
      rsc_pkg::BOR_IDLE: begin
        if (bor_trip) begin
          bor_next = rsc_pkg::BOR_HOLD;
        end
      end
      rsc_pkg::BOR_HOLD: begin
        if (above_rel_s && !below_s) begin
          bor_next = rsc_pkg::BOR_WAIT;
        end
      end
      rsc_pkg::BOR_WAIT: begin
        if (below_s) begin
          bor_next = rsc_pkg::BOR_HOLD;
        end else if (rel_cnt_reg == '0) begin
          bor_next = rsc_pkg::BOR_IDLE;
        end
      end
      default: begin
        bor_next = rsc_pkg::BOR_HOLD;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bor_reg <= rsc_pkg::BOR_IDLE;
    end else begin
      bor_reg <= bor_next;
    end
  end

  // Release wait counter, reloaded on every entry to the wait state
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rel_cnt_reg <= '0;
    end else if (bor_reg != rsc_pkg::BOR_WAIT) begin
      rel_cnt_reg <= CNT_W'(RELEASE_CYC - 1);
    end else if (rel_cnt_reg != '0) begin
      rel_cnt_reg <= rel_cnt_reg - CNT_W'(1);
    end
  end

  // Oscillator stop halts until a hardware reset clears it; set wins
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      osc_halt_reg <= 1'h0;
    end else if (osc_s && !osc_act_reg) begin
      osc_halt_reg <= 1'h1;
    end else if (hw_src) begin
      osc_halt_reg <= 1'h0;
    end
  end

  // System reset stretch: held while any source stands, released in sync
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sys_cnt_reg <= `RSC_RST_STRETCH;
      O_SYS_RST_N <= 1'h0;
    end else if (|src) begin
      sys_cnt_reg <= `RSC_RST_STRETCH;
      O_SYS_RST_N <= 1'h0;
    end else if (sys_cnt_reg != 4'h0) begin
      sys_cnt_reg <= sys_cnt_reg - 4'h1;
      O_SYS_RST_N <= 1'h0;
    end else begin
      O_SYS_RST_N <= 1'h1;
    end
  end

  // Hardware reset stretch: pin and brown-out only, reaches preserved set
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      hw_cnt_reg <= `RSC_RST_STRETCH;
      O_HW_RST_N <= 1'h0;
    end else if (hw_src) begin
      hw_cnt_reg <= `RSC_RST_STRETCH;
      O_HW_RST_N <= 1'h0;
    end else if (hw_cnt_reg != 4'h0) begin
      hw_cnt_reg <= hw_cnt_reg - 4'h1;
      O_HW_RST_N <= 1'h0;
    end else begin
      O_HW_RST_N <= 1'h1;
    end
  end

  // Cause record: the source set seen in the last cycle any was active
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cause_reg <= `RSC_RST_CAUSE_INIT;
    end else if (|src) begin
      cause_reg <= src;
    end
  end

  // Voltage detect controls: power-on reset only, so sw/wdt/osc keep them
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      det_en_reg    <= 2'h0;
      lvi_en_reg    <= 1'h0;
      stop_exit_reg <= 1'h0;
    end else begin
      if (wr_vdet) begin
        det_en_reg <= {w_data_reg[`RSC_BIT_LVD_EN], w_data_reg[`RSC_BIT_RLD_EN]};
      end
      if (wr_lvi) begin
        lvi_en_reg    <= w_data_reg[`RSC_BIT_LVI_EN];
        stop_exit_reg <= w_data_reg[`RSC_BIT_STOP_EXIT];
      end
    end
  end

  // Low voltage detected flag; a crossing beats a clear in the same cycle
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lv_det_reg  <= 1'h0;
      lv_prev_reg <= 1'h0;
    end else begin
      lv_prev_reg <= above_lv_s;
      if (!det_en_reg[1]) begin
        lv_det_reg <= 1'h0;
      end else if (lv_cross) begin
        lv_det_reg <= 1'h1;
      end else if (wr_lvi && !w_data_reg[`RSC_BIT_LV_DET]) begin
        lv_det_reg <= 1'h0;
      end
    end
  end

  // Processor mode: boot strap default on hardware reset only
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pm_reg <= 2'h0;
    end else if (hw_src) begin
      pm_reg <= {boot_s, 1'h0};
    end else if (wr_pm) begin
      pm_reg <= w_data_reg[1:0];
    end
  end

  // Software reset request is a one-cycle pulse; the bit reads 0
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sw_req_reg <= 1'h0;
    end else begin
      sw_req_reg <= wr_pm & w_data_reg[`RSC_BIT_SW_RST];
    end
  end

  // Ordinary control bits fall back under any internal reset
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wdt_sel_reg <= 1'h0;
      osc_act_reg <= 1'h0;
      vwr_en_reg  <= 1'h0;
    end else if (!O_SYS_RST_N) begin
      wdt_sel_reg <= 1'h0;
      osc_act_reg <= 1'h0;
      vwr_en_reg  <= 1'h0;
    end else begin
      if (wr_clk) begin
        wdt_sel_reg <= w_data_reg[`RSC_BIT_WDT_SEL];
        osc_act_reg <= w_data_reg[`RSC_BIT_OSC_ACT];
      end
      if (wr_prot) begin
        vwr_en_reg <= w_data_reg[`RSC_BIT_VWR_EN];
      end
    end
  end

  // Bus control pins while the reset pin is low
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_BUS_PIN_OE        <= 1'h0;
      O_CHIP_SELECT_ZERO  <= 1'h1;
      O_WRITE_STROBE      <= 1'h1;
      O_READ_STROBE       <= 1'h1;
      O_ADDR_LATCH_STROBE <= 1'h0;
    end else begin
      O_BUS_PIN_OE        <= ~pin_n_s & boot_s;
      O_CHIP_SELECT_ZERO  <= 1'h1;
      O_WRITE_STROBE      <= 1'h1;
      O_READ_STROBE       <= 1'h1;
      O_ADDR_LATCH_STROBE <= 1'h0;
    end
  end

  // Status outputs
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CPU_HALT  <= 1'h0;
      O_PROC_MODE <= 2'h0;
    end else begin
      O_CPU_HALT  <= osc_halt_reg;
      O_PROC_MODE <= pm_reg;
    end
  end

  // Read data; the above-threshold flag is 1 unless the detector runs
  always_comb begin
    rd_mux = 32'h0;
    if (addr_hit(I_ARADDR, `RSC_OFF_VDET_STATUS)) begin
      rd_mux[`RSC_BIT_ABOVE_FLAG] = lv_ok ? above_lv_s : 1'h1;
    end else if (addr_hit(I_ARADDR, `RSC_OFF_VDET_CTRL)) begin
      rd_mux[`RSC_BIT_RLD_EN] = det_en_reg[0];
      rd_mux[`RSC_BIT_LVD_EN] = det_en_reg[1];
    end else if (addr_hit(I_ARADDR, `RSC_OFF_LVI_CTRL)) begin
      rd_mux[`RSC_BIT_LVI_EN]    = lvi_en_reg;
      rd_mux[`RSC_BIT_STOP_EXIT] = stop_exit_reg;
      rd_mux[`RSC_BIT_LV_DET]    = lv_det_reg;
    end else if (addr_hit(I_ARADDR, `RSC_OFF_PROTECT)) begin
      rd_mux[`RSC_BIT_VWR_EN] = vwr_en_reg;
    end else if (addr_hit(I_ARADDR, `RSC_OFF_PROC_MODE)) begin
      rd_mux[1:0] = pm_reg;
    end else if (addr_hit(I_ARADDR, `RSC_OFF_CLK_CTRL)) begin
      rd_mux[`RSC_BIT_WDT_SEL] = wdt_sel_reg;
      rd_mux[`RSC_BIT_OSC_ACT] = osc_act_reg;
    end else if (addr_hit(I_ARADDR, `RSC_OFF_RST_CAUSE)) begin
      rd_mux[4:0] = cause_reg;
    end
  end

  // Write channel holding state
  always_comb begin
    aw_full_next = aw_full_reg | (I_AWVALID & O_AWREADY);
    w_full_next  = w_full_reg | (I_WVALID & O_WREADY);
    bvalid_next  = O_BVALID & ~I_BREADY;
    if (wr_fire) begin
      aw_full_next = 1'h0;
      w_full_next  = 1'h0;
      bvalid_next  = 1'h1;
    end
  end

  // Write slave: address and data in either order, answer after both
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      aw_full_reg <= 1'h0;
      w_full_reg  <= 1'h0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0;
      w_lane0_reg <= 1'h0;
      O_AWREADY   <= 1'h0;
      O_WREADY    <= 1'h0;
      O_BVALID    <= 1'h0;
      O_BRESP     <= `RSC_RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      O_AWREADY   <= ~aw_full_next & ~bvalid_next;
      O_WREADY    <= ~w_full_next & ~bvalid_next;
      O_BVALID    <= bvalid_next;
      if (I_AWVALID && O_AWREADY) begin
        aw_addr_reg <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_data_reg  <= I_WDATA;
        w_lane0_reg <= I_WSTRB[0];
      end
      if (wr_fire) begin
        O_BRESP <= addr_mapped(aw_addr_reg) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
      end
    end
  end

  // Read slave: one read at a time, data one cycle after the address
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_ARREADY <= 1'h0;
      O_RVALID  <= 1'h0;
      O_RDATA   <= 32'h0;
      O_RRESP   <= `RSC_RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      O_ARREADY <= 1'h0;
      O_RVALID  <= 1'h1;
      O_RDATA   <= rd_mux;
      O_RRESP   <= addr_mapped(I_ARADDR) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID  <= 1'h0;
      O_ARREADY <= 1'h1;
    end else if (!O_RVALID) begin
      O_ARREADY <= 1'h1;
    end
  end
endmodule

// >>> testbench/rsc_board.sv
// Board reset circuit model driving the reset pin.
// Assumes the main clock runs from time zero.
`timescale 1ns/1ps
module rsc_board #(
  parameter int PWR_WAIT = 16,
  parameter int MIN_CLK  = 20
) (
  input  wire logic i_main_clk,
  input  wire logic i_hold,
  output logic      o_reset_pin_n
);
  int cnt;
  initial begin
    o_reset_pin_n = 1'h0;
    cnt = 0;
  end
  // Pin low while asked; the power wait is always added, which only lengthens it
  always @(posedge i_main_clk) begin
    if (i_hold) begin
      cnt <= 0;
      o_reset_pin_n <= 1'h0;
    end else if (cnt < PWR_WAIT + MIN_CLK) begin
      cnt <= cnt + 1;
    end else begin
      o_reset_pin_n <= 1'h1;
    end
  end
endmodule

// >>> testbench/rsc_properties.sv
// Port-level checker of the reset source controller.
// Assumes it is bound into rsc_top and sees only its ports.
`timescale 1ns/1ps
module rsc_properties (
  input wire logic        I_CLK, I_RST_N, I_RESET_PIN_N, I_BOOT_MODE, I_STOP_MODE,
  input wire logic        I_AWVALID, I_WVALID, I_ARVALID, O_AWREADY, O_WREADY,
  input wire logic        O_BVALID, O_ARREADY, O_RVALID, O_SYS_RST_N, O_HW_RST_N,
  input wire logic        O_CPU_HALT, O_BUS_PIN_OE, O_CHIP_SELECT_ZERO,
  input wire logic        O_WRITE_STROBE, O_READ_STROBE, O_ADDR_LATCH_STROBE,
  input wire logic [1:0]  O_PROC_MODE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // Pin low long enough to pass the synchroniser
  sequence pin_low_s;
    !I_RESET_PIN_N [*3];
  endsequence
  // Stop mode with no pin or hardware reset under way
  sequence quiet_stop_s;
    (I_RESET_PIN_N && I_STOP_MODE && O_HW_RST_N) [*4];
  endsequence
  chk_pin_resets: assert property (pin_low_s |-> ##[0:2] !O_SYS_RST_N && !O_HW_RST_N)
    else $error("pin low did not reset");
  chk_stop_no_bor: assert property (quiet_stop_s |=> O_HW_RST_N)
    else $error("hardware reset in stop mode");
  chk_bus_drive: assert property ((!I_RESET_PIN_N && I_BOOT_MODE) [*4] |=> O_BUS_PIN_OE)
    else $error("bus pins not driven");
  chk_bus_levels: assert property (O_BUS_PIN_OE |-> O_CHIP_SELECT_ZERO && O_WRITE_STROBE
    && O_READ_STROBE && !O_ADDR_LATCH_STROBE) else $error("bus pin levels wrong");
  chk_release_late: assert property ($rose(O_SYS_RST_N) |-> $past(I_RESET_PIN_N, 8))
    else $error("reset released early");
  chk_mode_kept: assert property (O_HW_RST_N && $past(O_HW_RST_N)
    && !O_SYS_RST_N && !$past(O_SYS_RST_N) |-> $stable(O_PROC_MODE))
    else $error("mode lost in soft reset");
  chk_halt_reset: assert property ($rose(O_CPU_HALT) |-> ##[0:2] !O_SYS_RST_N)
    else $error("halt without reset");
  chk_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  chk_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
    |=> !O_BVALID ##1 O_BVALID) else $error("write answer timing");
endmodule
bind rsc_top rsc_properties u_chk (.*);

// >>> testbench/testbench.sv
// Self-checking bench of the reset source controller.
// Assumes rsc_top, the board model and the checker are compiled first.
`timescale 1ns/1ps
`include "rsc_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module testbench;
  logic        I_CLK = 1'h0, I_RST_N = 1'h0, I_BOOT_MODE = 1'h0, I_BELOW_RESET_THR = 1'h0;
  logic        I_ABOVE_RELEASE_THR = 1'h1, I_ABOVE_LV_THR = 1'h1, I_OSC_STOPPED = 1'h0;
  logic        I_WDT_UNDERFLOW = 1'h0, I_STOP_MODE = 1'h0, I_AWVALID = 1'h0, hold = 1'h1;
  logic        I_WVALID = 1'h0, I_BREADY = 1'h0, I_ARVALID = 1'h0, I_RREADY = 1'h0;
  logic [7:0]  I_AWADDR = 8'h00, I_ARADDR = 8'h00;
  logic [31:0] I_WDATA = 32'h0, O_RDATA;
  logic [3:0]  I_WSTRB = 4'hF;
  logic [1:0]  O_BRESP, O_RRESP, O_PROC_MODE, m;
  logic        I_RESET_PIN_N, O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic        O_SYS_RST_N, O_HW_RST_N, O_CPU_HALT, O_BUS_PIN_OE, O_CHIP_SELECT_ZERO;
  logic        O_WRITE_STROBE, O_READ_STROBE, O_ADDR_LATCH_STROBE;
  int          errors = 0, total_checks = 0;
  // Short waits keep the detector and release counts within a short run
  rsc_top #(.SETTLE_WAIT_NS(40), .RELEASE_WAIT_NS(40)) u_dut (.*);
  rsc_board u_board (.i_main_clk(I_CLK), .i_hold(hold), .o_reset_pin_n(I_RESET_PIN_N));
  always #2 I_CLK = ~I_CLK;
  // Cause register holds one bit per source: pin, brown-out, soft, watchdog, oscillator
  function automatic logic [31:0] cause_of(input int i);
    return 32'h1 << i;
  endfunction
  // Write: address and data offered together, bready held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    @(posedge I_CLK);
    {I_AWVALID, I_WVALID, I_BREADY} <= 3'h7;
    I_AWADDR <= a;
    I_WDATA <= d;
    do begin
      @(posedge I_CLK);
      if (O_AWREADY) I_AWVALID <= 1'h0;
      if (O_WREADY) I_WVALID <= 1'h0;
    end while (O_BVALID !== 1'h1);
    I_BREADY <= 1'h0;
    `CHK(O_BRESP, r)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    @(posedge I_CLK);
    {I_ARVALID, I_RREADY} <= 2'h3;
    I_ARADDR <= a;
    do begin
      @(posedge I_CLK);
      if (O_ARREADY) I_ARVALID <= 1'h0;
    end while (O_RVALID !== 1'h1);
    I_RREADY <= 1'h0;
    `CHK(O_RDATA, e)
    `CHK(O_RRESP, r)
  endtask
  // Bounded wait for the internal reset level
  task automatic wait_sys(input logic v);
    int n;
    n = 0;
    while (O_SYS_RST_N !== v && n < 300) begin
      @(posedge I_CLK);
      n++;
    end
    `CHK(O_SYS_RST_N, v)
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog: the sequence needs a few hundred cycles
  initial begin
    #100000;
    errors++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'hB2F5F937));
    repeat (12) @(posedge I_CLK);
    I_RST_N <= 1'h1;
    hold <= 1'h0;
    wait_sys(1'h1);
    rd(`RSC_OFF_RST_CAUSE, cause_of(0));
    rd(`RSC_OFF_VDET_STATUS, 32'h8);
    rd(8'h1C, 32'h0, `RSC_RESP_SLVERR);
    wr(8'h1C, 32'h8, `RSC_RESP_SLVERR);
    // A write with byte lane 0 off must leave the protect bit alone
    I_WSTRB <= 4'hE;
    wr(`RSC_OFF_PROTECT, 32'h8);
    I_WSTRB <= 4'hF;
    rd(`RSC_OFF_PROTECT, 32'h0);
    I_ABOVE_LV_THR <= 1'h0;
    wr(`RSC_OFF_VDET_CTRL, $urandom() & 32'hFFFFFF00 | 32'hC0);
    rd(`RSC_OFF_VDET_CTRL, 32'h0);
    wr(`RSC_OFF_PROTECT, 32'h8);
    wr(`RSC_OFF_VDET_CTRL, $urandom() & 32'hFFFFFF00 | 32'h80);
    rd(`RSC_OFF_VDET_STATUS, 32'h8);
    rd(`RSC_OFF_VDET_CTRL, 32'h80);
    repeat (20) @(posedge I_CLK);
    rd(`RSC_OFF_VDET_STATUS, 32'h0);
    I_ABOVE_LV_THR <= 1'h1;
    repeat (8) @(posedge I_CLK);
    rd(`RSC_OFF_LVI_CTRL, 32'h4);
    wr(`RSC_OFF_LVI_CTRL, 32'h4);
    rd(`RSC_OFF_LVI_CTRL, 32'h4);
    wr(`RSC_OFF_LVI_CTRL, 32'h3);
    rd(`RSC_OFF_LVI_CTRL, 32'h3);
    I_ABOVE_LV_THR <= 1'h0;
    wr(`RSC_OFF_VDET_CTRL, 32'h40);
    rd(`RSC_OFF_LVI_CTRL, 32'h3);
    rd(`RSC_OFF_VDET_STATUS, 32'h8);
    // Supply sags, first in stop mode where the trip is masked
    I_STOP_MODE <= 1'h1;
    I_BELOW_RESET_THR <= 1'h1;
    I_ABOVE_RELEASE_THR <= 1'h0;
    repeat (20) @(posedge I_CLK);
    `CHK(O_SYS_RST_N, 1'h1)
    I_STOP_MODE <= 1'h0;
    wait_sys(1'h0);
    repeat (30) @(posedge I_CLK);
    `CHK(O_HW_RST_N, 1'h0)
    I_BELOW_RESET_THR <= 1'h0;
    I_ABOVE_RELEASE_THR <= 1'h1;
    wait_sys(1'h1);
    rd(`RSC_OFF_RST_CAUSE, cause_of(1));
    rd(`RSC_OFF_VDET_CTRL, 32'h40);
    m = 2'($urandom());
    wr(`RSC_OFF_PROC_MODE, {30'h0, m});
    // Mode output is launched on the answer edge; look one edge later
    @(posedge I_CLK);
    `CHK(O_PROC_MODE, m)
    wr(`RSC_OFF_PROC_MODE, {28'h0, 2'h2, m});
    wait_sys(1'h0);
    `CHK(O_HW_RST_N, 1'h1)
    wait_sys(1'h1);
    `CHK(O_PROC_MODE, m)
    rd(`RSC_OFF_RST_CAUSE, cause_of(2));
    // Underflow ignored with select 0, resets with select 1
    for (int s = 0; s < 2; s++) begin
      wr(`RSC_OFF_CLK_CTRL, 32'(s));
      I_WDT_UNDERFLOW <= 1'h1;
      @(posedge I_CLK);
      I_WDT_UNDERFLOW <= 1'h0;
      repeat (6) @(posedge I_CLK);
      `CHK(O_SYS_RST_N, 1'(s == 0))
    end
    wait_sys(1'h1);
    rd(`RSC_OFF_RST_CAUSE, cause_of(3));
    rd(`RSC_OFF_VDET_CTRL, 32'h40);
    I_OSC_STOPPED <= 1'h1;
    wait_sys(1'h0);
    repeat (3) @(posedge I_CLK);
    `CHK(O_CPU_HALT, 1'h1)
    rd(`RSC_OFF_RST_CAUSE, cause_of(4));
    `CHK(O_PROC_MODE, m)
    I_OSC_STOPPED <= 1'h0;
    hold <= 1'h1;
    for (int b = 0; b < 2; b++) begin
      I_BOOT_MODE <= 1'(b);
      repeat (5) @(posedge I_CLK);
      `CHK(O_BUS_PIN_OE, 1'(b))
    end
    hold <= 1'h0;
    wait_sys(1'h1);
    `CHK(O_CPU_HALT, 1'h0)
    `CHK(O_PROC_MODE, 2'h2)
    rd(`RSC_OFF_RST_CAUSE, cause_of(0));
    wrap_up;
  end
endmodule
